// file: core/pscr_cnt_if.sv
`timescale 1ns/1ps
interface pscr_cnt_if #(
  parameter int WIDTH = 8
);
  logic             event_pulse;   // One increment request
  logic             clear_pulse;   // Clear-on-read strobe
  logic [WIDTH-1:0] count;
  logic             latch_flag;

  modport ctl (output event_pulse, output clear_pulse, input count, input latch_flag);
  modport cnt (input event_pulse, input clear_pulse, output count, output latch_flag);
endinterface // pscr_cnt_if

// file: core/pscr_event_counter.sv
`timescale 1ns/1ps
module pscr_event_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  pscr_cnt_if.cnt   cnt_if
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             flag_reg;
  logic             saturated;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pscr_event_counter: WIDTH must be at least 1");
    end
  endgenerate

  // Saturate rather than wrap; a clear that meets an event leaves a count of one
  assign saturated  = &count_reg;
  assign count_next = cnt_if.clear_pulse ?
                      (cnt_if.event_pulse ? WIDTH'(1) : '0) :
                      ((cnt_if.event_pulse && !saturated) ? count_reg + WIDTH'(1)
                                                           : count_reg);

  // Counter and its sticky latch; set beats clear so no event is lost
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= '0;
      flag_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      flag_reg  <= cnt_if.event_pulse | (flag_reg & ~cnt_if.clear_pulse);
    end
  end

  assign cnt_if.count      = count_reg;
  assign cnt_if.latch_flag = flag_reg;

endmodule // pscr_event_counter

// file: core/pscr_pkg.sv
package pscr_pkg;

  // ********************************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************************
  localparam logic [7:0] IDX_PHY_SUMMARY_STATUS     = 8'h10;
  localparam logic [7:0] IDX_FALSE_CARRIER_COUNTER  = 8'h14;
  localparam logic [7:0] IDX_RECEIVE_ERROR_COUNTER  = 8'h15;
  localparam logic [7:0] IDX_FAST_PCS_CONFIG_STATUS = 8'h16;

  // ********************************************************************
  // Summary status field positions
  // ********************************************************************
  localparam int SUM_LINK_BIT        = 0;
  localparam int SUM_SPEED_10_BIT    = 1;
  localparam int SUM_FULL_DUPLEX_BIT = 2;
  localparam int SUM_FC_LATCH_BIT    = 11;
  localparam int SUM_RXERR_LATCH_BIT = 13;

  // ********************************************************************
  // PCS configuration field positions and reset value
  // ********************************************************************
  localparam int PCS_TRUE_QUIET_BIT   = 10;
  localparam int PCS_FORCE_SD_BIT     = 9;
  localparam int PCS_SD_ALGO_BIT      = 8;
  localparam int PCS_DESC_TIMEOUT_BIT = 7;
  localparam int PCS_FORCE_100_BIT    = 5;
  localparam int PCS_NRZI_BYPASS_BIT  = 2;
  localparam logic [15:0] PCS_WRITE_MASK = 16'h07a4;
  localparam logic [15:0] PCS_RESET_VAL  = 16'h0100;

  // ********************************************************************
  // Counters
  // ********************************************************************
  localparam int CNT_WIDTH = 8;
  localparam int NUM_CNT   = 2;
  localparam int CNT_FC    = 0;
  localparam int CNT_RXERR = 1;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_PS       = 4000;
  localparam longint DESC_LONG_PS    = 64'd2000000000; // 2 ms
  localparam longint DESC_SHORT_PS   = 64'd722000000;  // 722 us
  localparam int DESC_LONG_CYCLES    = int'(DESC_LONG_PS / CLK_PERIOD_PS);
  localparam int DESC_SHORT_CYCLES   = int'(DESC_SHORT_PS / CLK_PERIOD_PS);
  localparam int DESC_CNT_W          = 20;

  // ********************************************************************
  // AXI responses
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/pscr_regs.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Summary bit 2 shows duplex: 1 full, 0 half, from negotiation or forcing.
// - Summary bit 1 shows speed: 1 means 10 Mb/s, 0 means 100 Mb/s.
// - Summary bit 0 mirrors link status; reading the summary never clears it.
// - Reserved upper bits of counter and PCS registers read zero, ignore writes.
// - False-carrier count in bits 7:0 at 0x14, one per false carrier.
// - False-carrier count sticks at FFh instead of wrapping.
// - Both counters are read-only and clear when read; an event in the reading cycle leaves one.
// - Receive-error count at 0x15 counts carriers holding invalid symbols.
// - Receive-error count advances at most once per carrier event.
// - A carrier event with collision never advances the receive-error count.
// - Receive-error count sticks at its maximum instead of wrapping.
// - PCS bit 10, reset 0, enables true quiet transmit at 100 Mb/s.
// - PCS bit 9, reset 0, forces signal detection in the PMA.
// - PCS bit 8, reset 1, picks enhanced signal detect, else reduced.
// - PCS bit 7, reset 0, sets descrambler timeout 2 ms, else 722 us.
// - PCS bit 5, reset 0, forces the 100 Mb/s link good.
// - PCS bit 2, reset 0, bypasses NRZI encode and decode.
// - False-carrier latch sets on an event, clears on reading 0x14.
// - Receive-error latch sets on an event, clears on reading 0x15.
module pscr_regs #(
  parameter int ADDR_W            = 8,
  parameter int DESC_LONG_CYCLES  = pscr_pkg::DESC_LONG_CYCLES,
  parameter int DESC_SHORT_CYCLES = pscr_pkg::DESC_SHORT_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [31:0]                   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [31:0]                        s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  // Status from the PHY core
  input  wire logic                          link_up_i,
  input  wire logic                          speed_10_i,
  input  wire logic                          full_duplex_i,
  // Receive datapath events
  input  wire logic                          false_carrier_i,
  input  wire logic                          carrier_valid_i,
  input  wire logic                          invalid_symbol_i,
  input  wire logic                          collision_i,
  // PCS controls
  output logic                               true_quiet_enable_o,
  output logic                               force_signal_detect_o,
  output logic                               signal_detect_algorithm_select_o,
  output logic                               descrambler_timeout_select_o,
  output logic                               force_100_good_link_o,
  output logic                               nrzi_bypass_o,
  output logic [pscr_pkg::DESC_CNT_W-1:0]    descrambler_timeout_cycles_o
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("pscr_regs: ADDR_W must be at least 8");
    end
    if (DESC_LONG_CYCLES < 1 || DESC_LONG_CYCLES >= (1 << pscr_pkg::DESC_CNT_W) ||
        DESC_SHORT_CYCLES < 1 || DESC_SHORT_CYCLES >= (1 << pscr_pkg::DESC_CNT_W))
    begin : g_bad_desc
      $error("pscr_regs: descrambler timeout counts out of range");
    end
  endgenerate

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [15:0] pcs_cfg_reg;
  logic [15:0] pcs_cfg_next;
  logic [pscr_pkg::DESC_CNT_W-1:0] desc_cycles_reg;
  logic        carrier_d_reg;
  logic        err_seen_reg;
  logic        col_seen_reg;

  logic        wr_go;
  logic        rd_go;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic        wr_aligned;
  logic        rd_aligned;
  logic        wr_is_pcs;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] wr_bitmask;
  logic [15:0] summary_val;
  logic [15:0] rd_val;
  logic        carrier_end;
  logic        rxerr_event;
  logic        rd_fc;
  logic        rd_rxerr;

  pscr_cnt_if #(.WIDTH(pscr_pkg::CNT_WIDTH)) cnt_bus [pscr_pkg::NUM_CNT] ();

  // ********************************************************************
  // Address decode
  // ********************************************************************
  // Only the low six index bits are decoded; higher address bits must be zero
  assign wr_go      = s_axi_awvalid_i && s_axi_wvalid_i && !awready_reg && !bvalid_reg;
  assign rd_go      = s_axi_arvalid_i && !arready_reg && !rvalid_reg;
  assign wr_idx     = s_axi_awaddr_i[7:2];
  assign rd_idx     = s_axi_araddr_i[7:2];
  assign wr_aligned = (s_axi_awaddr_i[1:0] == 2'h0) &&
                      ((s_axi_awaddr_i >> 8) == '0);
  assign rd_aligned = (s_axi_araddr_i[1:0] == 2'h0) &&
                      ((s_axi_araddr_i >> 8) == '0);
  assign wr_is_pcs  = wr_aligned && (wr_idx == pscr_pkg::IDX_FAST_PCS_CONFIG_STATUS[5:0]);
  // Writes to read-only registers are accepted and ignored
  assign wr_hit     = wr_aligned &&
                      (wr_idx == pscr_pkg::IDX_PHY_SUMMARY_STATUS[5:0] ||
                       wr_idx == pscr_pkg::IDX_FALSE_CARRIER_COUNTER[5:0] ||
                       wr_idx == pscr_pkg::IDX_RECEIVE_ERROR_COUNTER[5:0] ||
                       wr_is_pcs);
  assign rd_fc      = rd_aligned && (rd_idx == pscr_pkg::IDX_FALSE_CARRIER_COUNTER[5:0]);
  assign rd_rxerr   = rd_aligned && (rd_idx == pscr_pkg::IDX_RECEIVE_ERROR_COUNTER[5:0]);
  assign rd_hit     = rd_fc || rd_rxerr || (rd_aligned &&
                      (rd_idx == pscr_pkg::IDX_PHY_SUMMARY_STATUS[5:0] ||
                       rd_idx == pscr_pkg::IDX_FAST_PCS_CONFIG_STATUS[5:0]));

  // ********************************************************************
  // Register contents
  // ********************************************************************
  // Byte strobes gate the writable PCS bits; reserved bits never take a write
  assign wr_bitmask   = {{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}} &
                        pscr_pkg::PCS_WRITE_MASK;
  assign pcs_cfg_next = (pcs_cfg_reg & ~wr_bitmask) |
                        (s_axi_wdata_i[15:0] & wr_bitmask);

  // Summary is live status; reading it clears nothing
  always_comb begin
    summary_val = 16'h0000;
    summary_val[pscr_pkg::SUM_LINK_BIT]        = link_up_i;
    summary_val[pscr_pkg::SUM_SPEED_10_BIT]    = speed_10_i;
    summary_val[pscr_pkg::SUM_FULL_DUPLEX_BIT] = full_duplex_i;
    summary_val[pscr_pkg::SUM_FC_LATCH_BIT]    = cnt_bus[pscr_pkg::CNT_FC].latch_flag;
    summary_val[pscr_pkg::SUM_RXERR_LATCH_BIT] = cnt_bus[pscr_pkg::CNT_RXERR].latch_flag;
  end

  // Read mux; counter upper bits are padded with zero
  assign rd_val = !rd_aligned ? 16'h0000 :
                  (rd_idx == pscr_pkg::IDX_PHY_SUMMARY_STATUS[5:0]) ? summary_val :
                  rd_fc    ? {8'h00, cnt_bus[pscr_pkg::CNT_FC].count} :
                  rd_rxerr ? {8'h00, cnt_bus[pscr_pkg::CNT_RXERR].count} :
                  (rd_idx == pscr_pkg::IDX_FAST_PCS_CONFIG_STATUS[5:0]) ? pcs_cfg_reg :
                  16'h0000;

  // ********************************************************************
  // Receive-error qualification
  // ********************************************************************
  // Judged at carrier end so a late collision still vetoes the count
  assign carrier_end = carrier_d_reg && !carrier_valid_i;
  assign rxerr_event = carrier_end && (err_seen_reg || invalid_symbol_i) &&
                       !(col_seen_reg || collision_i);

  // Per-carrier memory of invalid symbols and collisions
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      carrier_d_reg <= 1'b0;
      err_seen_reg  <= 1'b0;
      col_seen_reg  <= 1'b0;
    end else begin
      carrier_d_reg <= carrier_valid_i;
      err_seen_reg  <= carrier_valid_i && (err_seen_reg || invalid_symbol_i);
      col_seen_reg  <= carrier_valid_i && (col_seen_reg || collision_i);
    end
  end

  // ********************************************************************
  // Event counters
  // ********************************************************************
  // Clear strobes fire in the rd_go cycle, one cycle before arready rises, with the data sampled
  assign cnt_bus[pscr_pkg::CNT_FC].event_pulse    = false_carrier_i;
  assign cnt_bus[pscr_pkg::CNT_FC].clear_pulse    = rd_go && rd_fc;
  assign cnt_bus[pscr_pkg::CNT_RXERR].event_pulse = rxerr_event;
  assign cnt_bus[pscr_pkg::CNT_RXERR].clear_pulse = rd_go && rd_rxerr;

  generate
    for (genvar gi = 0; gi < pscr_pkg::NUM_CNT; gi++) begin : g_cnt
      pscr_event_counter #(.WIDTH(pscr_pkg::CNT_WIDTH)) u_cnt (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .cnt_if  (cnt_bus[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // Write channel
  // ********************************************************************
  // Address and data are taken together; one write is outstanding at most
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pscr_pkg::RESP_OKAY;
    end else begin
      awready_reg <= wr_go;
      wready_reg  <= wr_go;
      if (awready_reg) begin
        bvalid_reg <= 1'b1;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_go) begin
        bresp_reg <= wr_hit ? pscr_pkg::RESP_OKAY : pscr_pkg::RESP_SLVERR;
      end
    end
  end

  // PCS configuration; bits steer the PMA and PCS directly
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pcs_cfg_reg <= pscr_pkg::PCS_RESET_VAL;
    end else if (wr_go && wr_is_pcs) begin
      pcs_cfg_reg <= pcs_cfg_next;
    end
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************
  // Data is sampled in the rd_go cycle, with the clear, so it holds the pre-clear count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= pscr_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= rd_go;
      if (rd_go) begin
        rdata_reg <= {16'h0000, rd_val};
        rresp_reg <= rd_hit ? pscr_pkg::RESP_OKAY : pscr_pkg::RESP_SLVERR;
      end
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Descrambler timeout count
  // ********************************************************************
  // Registered so the lock timer sees a clean value after a mode change
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      desc_cycles_reg <= pscr_pkg::DESC_CNT_W'(DESC_SHORT_CYCLES);
    end else begin
      desc_cycles_reg <= pcs_cfg_reg[pscr_pkg::PCS_DESC_TIMEOUT_BIT] ?
                         pscr_pkg::DESC_CNT_W'(DESC_LONG_CYCLES) :
                         pscr_pkg::DESC_CNT_W'(DESC_SHORT_CYCLES);
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign s_axi_awready_o                  = awready_reg;
  assign s_axi_wready_o                   = wready_reg;
  assign s_axi_bvalid_o                   = bvalid_reg;
  assign s_axi_bresp_o                    = bresp_reg;
  assign s_axi_arready_o                  = arready_reg;
  assign s_axi_rvalid_o                   = rvalid_reg;
  assign s_axi_rresp_o                    = rresp_reg;
  assign s_axi_rdata_o                    = rdata_reg;
  assign true_quiet_enable_o              = pcs_cfg_reg[pscr_pkg::PCS_TRUE_QUIET_BIT];
  assign force_signal_detect_o            = pcs_cfg_reg[pscr_pkg::PCS_FORCE_SD_BIT];
  assign signal_detect_algorithm_select_o = pcs_cfg_reg[pscr_pkg::PCS_SD_ALGO_BIT];
  assign descrambler_timeout_select_o     = pcs_cfg_reg[pscr_pkg::PCS_DESC_TIMEOUT_BIT];
  assign force_100_good_link_o            = pcs_cfg_reg[pscr_pkg::PCS_FORCE_100_BIT];
  assign nrzi_bypass_o                    = pcs_cfg_reg[pscr_pkg::PCS_NRZI_BYPASS_BIT];
  assign descrambler_timeout_cycles_o     = desc_cycles_reg;

endmodule // pscr_regs

// file: sim/pscr_regs_asserts.sv
`timescale 1ns/1ps
module pscr_regs_asserts #(
  parameter int ADDR_W            = 8,
  parameter int DESC_LONG_CYCLES  = 20,
  parameter int DESC_SHORT_CYCLES = 10
) (
  input wire logic                          clk_i,
  input wire logic                          reset_i,
  input wire logic                          s_axi_awready_o,
  input wire logic                          s_axi_wready_o,
  input wire logic                          s_axi_bvalid_o,
  input wire logic                          s_axi_bready_i,
  input wire logic [1:0]                    s_axi_bresp_o,
  input wire logic                          s_axi_arvalid_i,
  input wire logic [ADDR_W-1:0]             s_axi_araddr_i,
  input wire logic                          s_axi_arready_o,
  input wire logic                          s_axi_rvalid_o,
  input wire logic                          s_axi_rready_i,
  input wire logic [31:0]                   s_axi_rdata_o,
  input wire logic                          true_quiet_enable_o,
  input wire logic                          nrzi_bypass_o,
  input wire logic                          descrambler_timeout_select_o,
  input wire logic [pscr_pkg::DESC_CNT_W-1:0] descrambler_timeout_cycles_o
);
  // ********************************************************************
  // Read target tracking
  // ********************************************************************
  logic [ADDR_W-1:0] rd_addr_reg;
  // Address is still held by the master in the cycle arready pulses
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) rd_addr_reg <= '0;
    else if (s_axi_arvalid_i && s_axi_arready_o) rd_addr_reg <= s_axi_araddr_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_desc_long; descrambler_timeout_select_o |=>
    descrambler_timeout_cycles_o == 20'(DESC_LONG_CYCLES); endproperty
  a_desc_long: assert property (p_desc_long) else $error("long timeout missing");
  property p_desc_short; !descrambler_timeout_select_o |=>
    descrambler_timeout_cycles_o == 20'(DESC_SHORT_CYCLES); endproperty
  a_desc_short: assert property (p_desc_short) else $error("short timeout missing");
  property p_cnt_rsvd; s_axi_rvalid_o && (rd_addr_reg == 8'h50 || rd_addr_reg == 8'h54)
    |-> s_axi_rdata_o[15:8] == 8'h00; endproperty
  a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("counter upper bits set");
  property p_pcs_rsvd; s_axi_rvalid_o && rd_addr_reg == 8'h58
    |-> (s_axi_rdata_o[15:0] & ~pscr_pkg::PCS_WRITE_MASK) == 16'h0000; endproperty
  a_pcs_rsvd: assert property (p_pcs_rsvd) else $error("pcs reserved bits set");
  property p_pcs_bits; s_axi_rvalid_o && rd_addr_reg == 8'h58 |->
    s_axi_rdata_o[10] == true_quiet_enable_o && s_axi_rdata_o[2] == nrzi_bypass_o; endproperty
  a_pcs_bits: assert property (p_pcs_bits) else $error("pcs bits not driven");
  property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_after; s_axi_arready_o |=> s_axi_rvalid_o ##1 !s_axi_arready_o; endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");
  property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_wr_pair; s_axi_awready_o |-> s_axi_wready_o ##1
    (s_axi_bvalid_o && !s_axi_awready_o) ##1 !s_axi_awready_o; endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write handshake broken");
endmodule // pscr_regs_asserts

bind pscr_regs pscr_regs_asserts #(.ADDR_W(ADDR_W), .DESC_LONG_CYCLES(DESC_LONG_CYCLES),
  .DESC_SHORT_CYCLES(DESC_SHORT_CYCLES)) u_pscr_regs_asserts (.clk_i, .reset_i,
  .s_axi_awready_o, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_arvalid_i, .s_axi_araddr_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .true_quiet_enable_o, .nrzi_bypass_o, .descrambler_timeout_select_o,
  .descrambler_timeout_cycles_o);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ********************************************************************
  // Bench for the status, counter and PCS registers
  // ********************************************************************
  localparam int LONG_C = 20;
  localparam int SHORT_C = 10;
  localparam logic [1:0] OK = pscr_pkg::RESP_OKAY;
  localparam logic [1:0] ER = pscr_pkg::RESP_SLVERR;
  logic clk_i, reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, link_up_i, speed_10_i, full_duplex_i, false_carrier_i;
  logic carrier_valid_i, invalid_symbol_i, collision_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, true_quiet_enable_o;
  logic force_signal_detect_o, signal_detect_algorithm_select_o, descrambler_timeout_select_o;
  logic force_100_good_link_o, nrzi_bypass_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [pscr_pkg::DESC_CNT_W-1:0] descrambler_timeout_cycles_o;
  int n_errors = 0;
  int compares = 0;
  pscr_regs #(.DESC_LONG_CYCLES(LONG_C), .DESC_SHORT_CYCLES(SHORT_C)) u_pscr_regs (
    .clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .link_up_i, .speed_10_i,
    .full_duplex_i, .false_carrier_i, .carrier_valid_i, .invalid_symbol_i, .collision_i,
    .true_quiet_enable_o, .force_signal_detect_o, .signal_detect_algorithm_select_o,
    .descrambler_timeout_select_o, .force_100_good_link_o, .nrzi_bypass_o,
    .descrambler_timeout_cycles_o);
  // Free-running 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task give_verdict;
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait; values read right after the edge are what the edge sampled
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (s !== 1'b1 && n < 200);
    if (s !== 1'b1) begin n_errors++; give_verdict(); end
  endtask
  // Response readies are set by the main sequence; a stall scenario holds them low
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    wait_hi(s_axi_awready_o);
    chk(32'(s_axi_wready_o), 32'h1);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    wait_hi(s_axi_bvalid_o);
    chk(32'(s_axi_bresp_o), 32'(er));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    wait_hi(s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    wait_hi(s_axi_rvalid_o);
    chk(s_axi_rdata_o, exp);
    chk(32'(s_axi_rresp_o), 32'(er));
  endtask
  // False carrier held high for n cycles: each high cycle is one event
  task fc(input int n);
    false_carrier_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    false_carrier_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Three-cycle carrier, symbol errors and collision held throughout
  task car(input logic inv, input logic col);
    carrier_valid_i <= 1'b1;
    invalid_symbol_i <= inv;
    collision_i <= col;
    repeat (3) @(posedge clk_i);
    carrier_valid_i <= 1'b0;
    invalid_symbol_i <= 1'b0;
    collision_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Main sequence
  initial begin
    reset_i = 1'b1;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, false_carrier_i} = 4'h0;
    {carrier_valid_i, invalid_symbol_i, collision_i, full_duplex_i} = 4'h0;
    {link_up_i, speed_10_i, s_axi_bready_i, s_axi_rready_i} = 4'hf;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h58, 32'h0100, OK);
    rd(8'h50, 32'h0, OK);
    rd(8'h54, 32'h0, OK);
    rd(8'h40, 32'h3, OK);
    rd(8'h40, 32'h3, OK);
    speed_10_i <= 1'b0;
    full_duplex_i <= 1'b1;
    rd(8'h40, 32'h5, OK);
    fc(5);
    rd(8'h40, 32'h805, OK);
    rd(8'h50, 32'h5, OK);
    rd(8'h50, 32'h0, OK);
    rd(8'h40, 32'h5, OK);
    fc(2);
    wr(8'h50, 32'hffff, OK);
    rd(8'h50, 32'h2, OK);
    fc(300);
    rd(8'h50, 32'hff, OK);
    // Events keep arriving across the clearing read; none may be lost
    false_carrier_i <= 1'b1;
    rd(8'h50, 32'h0, OK);
    false_carrier_i <= 1'b0;
    rd(8'h50, 32'h3, OK);
    car(1'b1, 1'b0);
    rd(8'h40, 32'h2005, OK);
    rd(8'h54, 32'h1, OK);
    rd(8'h40, 32'h5, OK);
    car(1'b1, 1'b1);
    rd(8'h54, 32'h0, OK);
    car(1'b0, 1'b0);
    rd(8'h54, 32'h0, OK);
    repeat (257) car(1'b1, 1'b0);
    rd(8'h54, 32'hff, OK);
    wr(8'h58, 32'he7a4, OK);
    rd(8'h58, 32'h07a4, OK);
    chk(32'({true_quiet_enable_o, force_signal_detect_o, signal_detect_algorithm_select_o,
      descrambler_timeout_select_o, force_100_good_link_o, nrzi_bypass_o}), 32'h3f);
    repeat (2) @(posedge clk_i);
    chk(32'(descrambler_timeout_cycles_o), 32'(LONG_C));
    wr(8'h58, 32'h0, OK);
    repeat (2) @(posedge clk_i);
    chk(32'({signal_detect_algorithm_select_o, descrambler_timeout_cycles_o}), 32'(SHORT_C));
    // Stalled responses must hold until the master finally accepts them
    {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
    wr(8'h58, 32'h0080, OK);
    rd(8'h58, 32'h0080, OK);
    repeat (3) @(posedge clk_i);
    {s_axi_bready_i, s_axi_rready_i} <= 2'h3;
    @(posedge clk_i);
    wr(8'h44, 32'h1, ER);
    rd(8'h44, 32'h0, ER);
    give_verdict();
  end
  // Hang guard
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end
endmodule // tb_top
